//--- inc/brp_pkg.sv
package brp_pkg;

	// ------------------------------------------------------------
	// Bus commands (read family only)
	// ------------------------------------------------------------
	localparam logic [3:0] CMD_IO_READ = 4'h2;
	localparam logic [3:0] CMD_MEM_READ = 4'h6;
	localparam logic [3:0] CMD_CFG_READ = 4'ha;
	localparam logic [3:0] CMD_MEM_READ_MULT = 4'hc;
	localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;

	// ------------------------------------------------------------
	// Prefetch boundaries in DWORDs
	// ------------------------------------------------------------
	localparam int CNT_W = 11;
	localparam logic [CNT_W-1:0] BND_ONE_DW = 11'h001;
	localparam logic [CNT_W-1:0] BND_LINE_DEF = 11'h010;
	localparam logic [CNT_W-1:0] BND_MULT_DEF = 11'h020;
	localparam logic [CNT_W-1:0] BND_4KB = 11'h400;

	// ------------------------------------------------------------
	// Dynamic prefetch field and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] DYN_OFF = 2'h0;
	localparam logic [1:0] DYN_SHIFT_RST = 2'h0;
	localparam logic [CNT_W-1:0] CNT_RST = 11'h000;
	localparam logic [CNT_W-1:0] BUF_SHORT_DEF = 11'h002;

	// Request word carried by the issue buffer
	localparam int REQ_W = 1 + 4 + 32 + 4 + CNT_W;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FETCH = 3'b010,
		ST_DRAIN = 3'b100
	} brp_state_t;

endpackage : brp_pkg

//--- verilog/brp_buf.sv
`timescale 1ns/10ps
`default_nettype none

// Shift-style buffer: the head entry always sits in slot 0, so the
// output data and flags come straight from flip-flops.
module brp_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// Fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [$clog2(DEPTH+1)-1:0] count_reg;
	logic [$clog2(DEPTH+1)-1:0] count_next;
	logic push;
	logic pop;

	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign out_data_out = mem_reg[0];

	// Occupancy follows push and pop
	always_comb begin
		count_next = count_reg;
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	// Count and registered flags
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_reg <= '0;
			out_valid_out <= 1'b0;
			in_ready_out <= 1'b1;
		end else if (ce_in) begin
			count_reg <= count_next;
			out_valid_out <= (count_next != '0);
			in_ready_out <= (count_next != DEPTH[$clog2(DEPTH+1)-1:0]);
		end
	end

	// Entries shift toward the head on a pop; a push lands behind the last
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (ce_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (pop && i < DEPTH - 1) begin
					mem_reg[i] <= mem_reg[i+1];
				end
				if (push && (int'(count_reg) - (pop ? 1 : 0)) == i) begin
					mem_reg[i] <= in_data_in;
				end
			end
		end
	end

endmodule : brp_buf

`default_nettype wire

//--- verilog/brp_top.sv
`timescale 1ns/10ps
`default_nettype none

//Function
//- Every crossing read is delayed and classed prefetchable or not before issue.
//- Prefetchable reads fetch many DWORDs ahead and drive all byte enables on.
//- Line and multiple reads, and memory reads in prefetchable space, prefetch.
//- Prefetch is cut short on low free buffer space and at boundaries.
//- Dynamic control adjusts prefetch length per burst outcome when enabled.
//- Non-prefetchable reads fetch one DWORD, keep byte enables, disconnect after it.
//- I/O, configuration and non-prefetchable memory reads are never prefetched.
//- Prefetch stops at the aligned boundary unless the target disconnected earlier.
//- Disconnect with the last prefetched DWORD; discard what was not delivered.
//- Flow-through prefetches to the 4KB boundary or until FRAME deasserts.
//- Memory read and read line stop at 16 DWORDs or the cache line.
//- Read multiple stops at 32 DWORDs when cache line size is 0 or 16.
//- Read multiple stops at twice the cache line for legal sizes.
//- Downstream memory reads prefetch by space; upstream by a programmable choice.
//- The three memory read commands alias one another when matching requests.
module brp_top #(
	parameter logic [brp_pkg::CNT_W-1:0] BUF_SHORT_DW = brp_pkg::BUF_SHORT_DEF
) (
	// Clock, reset and enable
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CE_IN,
	// Configuration
	input wire logic [7:0] CFG_CLS_IN,
	input wire logic CFG_UP_MR_PREF_IN,
	input wire logic [1:0] CFG_DYN_PREF_IN,
	input wire logic FLOW_THROUGH_IN,
	input wire logic [brp_pkg::CNT_W-1:0] BUF_FREE_IN,
	// Initiator bus pin
	input wire logic INIT_FRAME_N_IN,
	// Captured read request
	input wire logic REQ_VALID_IN,
	output logic REQ_READY_OUT,
	input wire logic [3:0] REQ_CMD_IN,
	input wire logic [31:0] REQ_ADDR_IN,
	input wire logic [3:0] REQ_BE_N_IN,
	input wire logic REQ_DOWNSTREAM_IN,
	input wire logic REQ_PREF_SPACE_IN,
	// Target bus issue
	output logic TGT_VALID_OUT,
	input wire logic TGT_READY_IN,
	output logic [3:0] TGT_CMD_OUT,
	output logic [31:0] TGT_ADDR_OUT,
	output logic [3:0] TGT_BE_N_OUT,
	output logic TGT_PREF_OUT,
	output logic [brp_pkg::CNT_W-1:0] TGT_DWORDS_OUT,
	// Target bus progress
	input wire logic TGT_DATA_IN,
	input wire logic TGT_DISC_IN,
	output logic FETCH_STOP_OUT,
	// Initiator bus delivery
	input wire logic INIT_XFER_IN,
	input wire logic INIT_DONE_IN,
	output logic INIT_DISC_OUT,
	output logic DISCARD_OUT,
	output logic BUSY_OUT,
	// Request matching
	input wire logic [3:0] ALIAS_CMD_A_IN,
	input wire logic [3:0] ALIAS_CMD_B_IN,
	input wire logic ALIAS_ADDR_EQ_IN,
	output logic ALIAS_MATCH_OUT,
	// Dynamic prefetch status
	output logic [1:0] DYN_SHIFT_OUT
);

	localparam int CW = brp_pkg::CNT_W;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	brp_pkg::brp_state_t state_reg;
	brp_pkg::brp_state_t state_next;
	logic frame_n_s1_reg;
	logic frame_n_s2_reg;
	logic req_ready_reg;
	logic [CW-1:0] limit_reg;
	logic [CW-1:0] ft_limit_reg;
	logic pref_reg;
	logic [CW-1:0] fetched_reg;
	logic [CW-1:0] fetched_next;
	logic [CW-1:0] deliv_reg;
	logic [CW-1:0] deliv_next;
	logic [1:0] dyn_shift_reg;
	logic init_disc_reg;
	logic discard_reg;
	logic alias_match_reg;
	logic accept;
	logic is_mem_rd;
	logic pref;
	logic cls_ok;
	logic [CW-1:0] base_bnd;
	logic [CW-1:0] bnd;
	logic [CW-1:0] dwords;
	logic [CW-1:0] ft_dwords;
	logic [3:0] be_n;
	logic buf_in_ready;
	logic buf_out_valid;
	logic [brp_pkg::REQ_W-1:0] buf_out_data;
	logic fetch_end;
	logic burst_end;
	logic [CW-1:0] act_limit;

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------

	// FRAME comes from the bus pin, so it is retimed before use
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			frame_n_s1_reg <= 1'b1;
			frame_n_s2_reg <= 1'b1;
		end else if (CE_IN) begin
			frame_n_s1_reg <= INIT_FRAME_N_IN;
			frame_n_s2_reg <= frame_n_s1_reg;
		end
	end

	// ------------------------------------------------------------
	// Classification and boundary
	// ------------------------------------------------------------

	// Memory read family, used for classing and for aliasing
	function automatic logic mem_rd_fn(input logic [3:0] cmd);
		mem_rd_fn = (cmd == brp_pkg::CMD_MEM_READ) ||
			(cmd == brp_pkg::CMD_MEM_READ_LINE) ||
			(cmd == brp_pkg::CMD_MEM_READ_MULT);
	endfunction : mem_rd_fn

	// Prefetch decision per command and direction
	always_comb begin
		is_mem_rd = mem_rd_fn(REQ_CMD_IN);
		pref = 1'b0;
		if (REQ_CMD_IN == brp_pkg::CMD_MEM_READ_LINE ||
			REQ_CMD_IN == brp_pkg::CMD_MEM_READ_MULT) begin
			pref = 1'b1;
		end else if (REQ_CMD_IN == brp_pkg::CMD_MEM_READ) begin
			pref = REQ_DOWNSTREAM_IN ? REQ_PREF_SPACE_IN : CFG_UP_MR_PREF_IN;
		end
		// I/O, configuration and anything else stay single DWORD
		if (!is_mem_rd) begin
			pref = 1'b0;
		end
	end

	// Legal line sizes; any other value behaves like zero
	assign cls_ok = (CFG_CLS_IN == 8'h01) || (CFG_CLS_IN == 8'h02) ||
		(CFG_CLS_IN == 8'h04) || (CFG_CLS_IN == 8'h08) ||
		(CFG_CLS_IN == 8'h10);

	// Aligned boundary size in DWORDs
	always_comb begin
		if (REQ_CMD_IN == brp_pkg::CMD_MEM_READ_MULT) begin
			base_bnd = cls_ok ? {CFG_CLS_IN[CW-5:0], 4'h0} >> 3 : brp_pkg::BND_MULT_DEF;
		end else begin
			base_bnd = cls_ok ? {3'h0, CFG_CLS_IN} : brp_pkg::BND_LINE_DEF;
		end
		// Dynamic length widens the window by whole powers of two
		bnd = (CFG_DYN_PREF_IN != brp_pkg::DYN_OFF) ? base_bnd << dyn_shift_reg : base_bnd;
		if (bnd > brp_pkg::BND_4KB) begin
			bnd = brp_pkg::BND_4KB;
		end
		// Distance from the start address to the next aligned boundary
		dwords = bnd - (REQ_ADDR_IN[CW:2] & (bnd - 1'b1));
		ft_dwords = brp_pkg::BND_4KB - {1'b0, REQ_ADDR_IN[11:2]};
		if (!pref) begin
			dwords = brp_pkg::BND_ONE_DW;
			ft_dwords = brp_pkg::BND_ONE_DW;
		end
	end

	// Prefetch forces every lane on; single reads keep the initiator lanes
	assign be_n = pref ? 4'h0 : REQ_BE_N_IN;

	// ------------------------------------------------------------
	// Issue buffer toward the target bus
	// ------------------------------------------------------------

	// Each accepted read is queued with its class, never passed raw
	assign accept = REQ_VALID_IN && req_ready_reg;

	brp_buf #(
		.WIDTH(brp_pkg::REQ_W),
		.DEPTH(2)
	) u_issue_buf (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.ce_in(CE_IN),
		.in_valid_in(accept),
		.in_ready_out(buf_in_ready),
		.in_data_in({pref, REQ_CMD_IN, REQ_ADDR_IN, be_n, dwords}),
		.out_valid_out(buf_out_valid),
		.out_ready_in(TGT_READY_IN),
		.out_data_out(buf_out_data)
	);

	assign TGT_VALID_OUT = buf_out_valid;
	assign TGT_PREF_OUT = buf_out_data[brp_pkg::REQ_W-1];
	assign TGT_CMD_OUT = buf_out_data[brp_pkg::REQ_W-2 -: 4];
	assign TGT_ADDR_OUT = buf_out_data[brp_pkg::REQ_W-6 -: 32];
	assign TGT_BE_N_OUT = buf_out_data[CW+3 -: 4];
	assign TGT_DWORDS_OUT = buf_out_data[CW-1:0];

	// ------------------------------------------------------------
	// Fetch and delivery sequencing
	// ------------------------------------------------------------

	// Flow-through extends the window to the 4KB boundary
	assign act_limit = FLOW_THROUGH_IN ? ft_limit_reg : limit_reg;

	// Fetch ends at the boundary, on target disconnect, low space or FRAME release
	always_comb begin
		fetched_next = fetched_reg;
		if (state_reg == brp_pkg::ST_FETCH && TGT_DATA_IN) begin
			fetched_next = fetched_reg + 1'b1;
		end
		fetch_end = (fetched_next >= act_limit) || TGT_DISC_IN;
		if (pref_reg && BUF_FREE_IN < BUF_SHORT_DW) begin
			fetch_end = 1'b1;
		end
		if (pref_reg && FLOW_THROUGH_IN && frame_n_s2_reg) begin
			fetch_end = 1'b1;
		end
	end

	// Delivered count
	always_comb begin
		deliv_next = deliv_reg;
		if (state_reg != brp_pkg::ST_IDLE && INIT_XFER_IN && deliv_reg < fetched_reg) begin
			deliv_next = deliv_reg + 1'b1;
		end
	end

	// Burst is over once the initiator quits or has taken the last word
	assign burst_end = (state_reg != brp_pkg::ST_IDLE) &&
		(INIT_DONE_IN || (state_reg == brp_pkg::ST_DRAIN && deliv_next == fetched_reg));

	// Next state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			brp_pkg::ST_IDLE: begin
				if (accept) begin
					state_next = brp_pkg::ST_FETCH;
				end
			end
			brp_pkg::ST_FETCH: begin
				if (INIT_DONE_IN) begin
					state_next = brp_pkg::ST_IDLE;
				end else if (fetch_end) begin
					state_next = brp_pkg::ST_DRAIN;
				end
			end
			brp_pkg::ST_DRAIN: begin
				if (burst_end) begin
					state_next = brp_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// State register and request handshake
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state_reg <= brp_pkg::ST_IDLE;
			req_ready_reg <= 1'b0;
			BUSY_OUT <= 1'b0;
		end else if (CE_IN) begin
			state_reg <= state_next;
			BUSY_OUT <= (state_next != brp_pkg::ST_IDLE);
			// One read in flight keeps fetch and delivery counts unambiguous
			req_ready_reg <= (state_next == brp_pkg::ST_IDLE) && buf_in_ready && !accept;
		end
	end

	// Window latched at acceptance
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			limit_reg <= brp_pkg::BND_ONE_DW;
			ft_limit_reg <= brp_pkg::BND_ONE_DW;
			pref_reg <= 1'b0;
		end else if (CE_IN && accept) begin
			limit_reg <= dwords;
			ft_limit_reg <= ft_dwords;
			pref_reg <= pref;
		end
	end

	// Fetch and delivery counters restart with each read
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			fetched_reg <= brp_pkg::CNT_RST;
			deliv_reg <= brp_pkg::CNT_RST;
		end else if (CE_IN) begin
			if (accept) begin
				fetched_reg <= brp_pkg::CNT_RST;
				deliv_reg <= brp_pkg::CNT_RST;
			end else begin
				fetched_reg <= fetched_next;
				deliv_reg <= deliv_next;
			end
		end
	end

	// Disconnect marks the last fetched word; leftovers are dropped
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			init_disc_reg <= 1'b0;
			discard_reg <= 1'b0;
			FETCH_STOP_OUT <= 1'b0;
		end else if (CE_IN) begin
			init_disc_reg <= (state_next == brp_pkg::ST_DRAIN) &&
				(deliv_next + 1'b1 == fetched_next);
			discard_reg <= burst_end && (deliv_next < fetched_next);
			FETCH_STOP_OUT <= (state_next == brp_pkg::ST_DRAIN);
		end
	end

	// ------------------------------------------------------------
	// Dynamic prefetch length
	// ------------------------------------------------------------

	// Field value also caps the widening, so 01 is the most cautious setting
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			dyn_shift_reg <= brp_pkg::DYN_SHIFT_RST;
		end else if (CE_IN) begin
			if (CFG_DYN_PREF_IN == brp_pkg::DYN_OFF) begin
				dyn_shift_reg <= brp_pkg::DYN_SHIFT_RST;
			end else if (burst_end && pref_reg) begin
				// Whole window consumed: demand was larger, grow
				if (deliv_next == limit_reg && dyn_shift_reg < CFG_DYN_PREF_IN) begin
					dyn_shift_reg <= dyn_shift_reg + 1'b1;
				end else if ({deliv_next, 1'b0} < {1'b0, limit_reg} &&
					dyn_shift_reg != 2'h0) begin
					dyn_shift_reg <= dyn_shift_reg - 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Request matching
	// ------------------------------------------------------------

	// Repeated reads match a queued one across the memory read family
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			alias_match_reg <= 1'b0;
		end else if (CE_IN) begin
			alias_match_reg <= ALIAS_ADDR_EQ_IN &&
				((mem_rd_fn(ALIAS_CMD_A_IN) && mem_rd_fn(ALIAS_CMD_B_IN)) ||
				(ALIAS_CMD_A_IN == ALIAS_CMD_B_IN));
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign REQ_READY_OUT = req_ready_reg;
	assign INIT_DISC_OUT = init_disc_reg;
	assign DISCARD_OUT = discard_reg;
	assign ALIAS_MATCH_OUT = alias_match_reg;
	assign DYN_SHIFT_OUT = dyn_shift_reg;

endmodule : brp_top

`default_nettype wire

//--- testbench/brp_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module brp_top_asserts (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CE_IN,
	// Configuration
	input wire logic [7:0] CFG_CLS_IN,
	input wire logic [1:0] CFG_DYN_PREF_IN,
	input wire logic FLOW_THROUGH_IN,
	// Request and issue
	input wire logic REQ_VALID_IN,
	input wire logic REQ_READY_OUT,
	input wire logic TGT_VALID_OUT,
	input wire logic [3:0] TGT_CMD_OUT,
	input wire logic [31:0] TGT_ADDR_OUT,
	input wire logic [3:0] TGT_BE_N_OUT,
	input wire logic TGT_PREF_OUT,
	input wire logic [brp_pkg::CNT_W-1:0] TGT_DWORDS_OUT,
	// Progress and matching
	input wire logic FETCH_STOP_OUT,
	input wire logic INIT_DISC_OUT,
	input wire logic DISCARD_OUT,
	input wire logic [3:0] ALIAS_CMD_A_IN,
	input wire logic [3:0] ALIAS_CMD_B_IN,
	input wire logic ALIAS_ADDR_EQ_IN,
	input wire logic ALIAS_MATCH_OUT,
	input wire logic [1:0] DYN_SHIFT_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	// Memory read family, which aliases for matching
	function automatic logic mem_rd(input logic [3:0] c);
		return c inside {brp_pkg::CMD_MEM_READ, brp_pkg::CMD_MEM_READ_LINE, brp_pkg::CMD_MEM_READ_MULT};
	endfunction : mem_rd

	// Boundary checks only hold with no dynamic shift and no flow-through
	property p_accept;
		REQ_VALID_IN && REQ_READY_OUT && CE_IN |=> TGT_VALID_OUT && !REQ_READY_OUT;
	endproperty
	a_accept: assert property (p_accept) else $error("accepted read not issued");
	property p_be;
		TGT_VALID_OUT && TGT_PREF_OUT |-> TGT_BE_N_OUT == 4'h0;
	endproperty
	a_be: assert property (p_be) else $error("prefetch byte enables not all on");
	property p_one;
		TGT_VALID_OUT && !TGT_PREF_OUT |-> TGT_DWORDS_OUT == brp_pkg::BND_ONE_DW;
	endproperty
	a_one: assert property (p_one) else $error("non-prefetch length not one");
	property p_class;
		TGT_VALID_OUT && TGT_CMD_OUT != brp_pkg::CMD_MEM_READ |-> TGT_PREF_OUT == mem_rd(TGT_CMD_OUT);
	endproperty
	a_class: assert property (p_class) else $error("wrong read class");
	property p_line;
		TGT_VALID_OUT && TGT_PREF_OUT && TGT_CMD_OUT != brp_pkg::CMD_MEM_READ_MULT
			&& !(CFG_CLS_IN inside {8'h01, 8'h02, 8'h04, 8'h08}) && DYN_SHIFT_OUT == 2'h0
			&& !FLOW_THROUGH_IN |-> TGT_DWORDS_OUT == 11'h010 - {7'h00, TGT_ADDR_OUT[5:2]};
	endproperty
	a_line: assert property (p_line) else $error("line read boundary wrong");
	property p_mult;
		TGT_VALID_OUT && TGT_CMD_OUT == brp_pkg::CMD_MEM_READ_MULT
			&& !(CFG_CLS_IN inside {8'h01, 8'h02, 8'h04, 8'h08}) && DYN_SHIFT_OUT == 2'h0
			&& !FLOW_THROUGH_IN |-> TGT_DWORDS_OUT == 11'h020 - {6'h00, TGT_ADDR_OUT[6:2]};
	endproperty
	a_mult: assert property (p_mult) else $error("multiple read boundary wrong");
	property p_alias;
		ALIAS_ADDR_EQ_IN && mem_rd(ALIAS_CMD_A_IN) && mem_rd(ALIAS_CMD_B_IN) && CE_IN
			|=> ALIAS_MATCH_OUT;
	endproperty
	a_alias: assert property (p_alias) else $error("memory reads did not alias");
	property p_disc;
		INIT_DISC_OUT |-> FETCH_STOP_OUT;
	endproperty
	a_disc: assert property (p_disc) else $error("disconnect before fetch end");
	property p_drop;
		DISCARD_OUT && CE_IN |=> !DISCARD_OUT;
	endproperty
	a_drop: assert property (p_drop) else $error("discard longer than a pulse");
	property p_dyn;
		CFG_DYN_PREF_IN == brp_pkg::DYN_OFF && CE_IN |=> DYN_SHIFT_OUT == brp_pkg::DYN_SHIFT_RST;
	endproperty
	a_dyn: assert property (p_dyn) else $error("shift kept with control off");
endmodule : brp_top_asserts

bind brp_top brp_top_asserts brp_top_asserts_inst (.*);

`default_nettype wire

//--- testbench/brp_partner.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Far side: target answering the issued read
// ------------------------------------------------------------
module brp_partner (
	// Clock
	input wire logic clk_in,
	// Issue from the bridge
	input wire logic valid_in,
	input wire logic [10:0] dwords_in,
	input wire logic [31:0] addr_in,
	input wire logic stop_in,
	input wire logic ft_in,
	// Scenario knobs
	input wire logic [10:0] disc_in,
	input wire logic [1:0] wait_in,
	// Answers
	output logic ready_out,
	output logic data_out,
	output logic disc_out
);
	logic [10:0] lim;
	logic cut;
	int n;

	// Stall a chosen number of cycles, then stream one DWORD a cycle
	initial begin
		ready_out = 1'b0;
		data_out = 1'b0;
		disc_out = 1'b0;
		forever begin
			@(posedge clk_in);
			#1;
			if (valid_in === 1'b1) begin
				// A fetch the bridge already ended while we stalled gets no data
				cut = (stop_in === 1'b1);
				repeat (wait_in) begin
					@(posedge clk_in);
					#1;
					cut = cut || (stop_in === 1'b1);
				end
				// Flow-through bursts run on to the 4KB edge
				lim = ft_in ? 11'h400 - {1'b0, addr_in[11:2]} : dwords_in;
				ready_out = 1'b1;
				@(posedge clk_in);
				#1;
				ready_out = 1'b0;
				n = 0;
				while (n < lim && !cut && stop_in !== 1'b1) begin
					data_out = 1'b1;
					disc_out = (n + 1 == disc_in);
					n++;
					if (disc_out) lim = 11'(n);
					@(posedge clk_in);
					#1;
				end
				data_out = 1'b0;
				disc_out = 1'b0;
			end
		end
	end
endmodule : brp_partner

`default_nettype wire

//--- testbench/tb_brp_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_brp_top;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic CLK_IN = 1'b0, RST_N_IN = 1'b0, CE_IN = 1'b1;
	logic [7:0] CFG_CLS_IN = 8'h00;
	logic [1:0] CFG_DYN_PREF_IN = 2'h0, stall = 2'h0;
	logic CFG_UP_MR_PREF_IN = 1'b0, FLOW_THROUGH_IN = 1'b0, INIT_FRAME_N_IN = 1'b0;
	logic [brp_pkg::CNT_W-1:0] BUF_FREE_IN = 11'h040, disc_at = 11'h001;
	logic REQ_VALID_IN = 1'b0, REQ_DOWNSTREAM_IN = 1'b0, REQ_PREF_SPACE_IN = 1'b0;
	logic [3:0] REQ_CMD_IN = 4'h0, REQ_BE_N_IN = 4'h0, ALIAS_CMD_A_IN = 4'h0, ALIAS_CMD_B_IN = 4'h0;
	logic [31:0] REQ_ADDR_IN = 32'h0;
	logic INIT_XFER_IN = 1'b0, INIT_DONE_IN = 1'b0, ALIAS_ADDR_EQ_IN = 1'b0, chk_f = 1'b1;
	wire logic TGT_READY_IN, TGT_DATA_IN, TGT_DISC_IN, REQ_READY_OUT, TGT_VALID_OUT, TGT_PREF_OUT;
	wire logic FETCH_STOP_OUT, INIT_DISC_OUT, DISCARD_OUT, BUSY_OUT, ALIAS_MATCH_OUT;
	wire logic [3:0] TGT_CMD_OUT, TGT_BE_N_OUT;
	wire logic [31:0] TGT_ADDR_OUT;
	wire logic [brp_pkg::CNT_W-1:0] TGT_DWORDS_OUT;
	wire logic [1:0] DYN_SHIFT_OUT;
	int error_cnt = 0, check_count = 0, fcnt = 0, dcnt = 0, fgot = 0, sh = 0, i;
	logic [3:0] cmds [5] = '{brp_pkg::CMD_IO_READ, brp_pkg::CMD_MEM_READ, brp_pkg::CMD_CFG_READ,
		brp_pkg::CMD_MEM_READ_MULT, brp_pkg::CMD_MEM_READ_LINE};
	logic [7:0] clsv [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h03, 8'h20};

	// ------------------------------------------------------------
	// Design, far side and clock
	// ------------------------------------------------------------
	brp_top brp_top_inst (.*);
	brp_partner brp_partner_inst (.clk_in(CLK_IN), .valid_in(TGT_VALID_OUT),
		.dwords_in(TGT_DWORDS_OUT), .addr_in(TGT_ADDR_OUT), .stop_in(FETCH_STOP_OUT),
		.ft_in(FLOW_THROUGH_IN), .disc_in(disc_at), .wait_in(stall), .ready_out(TGT_READY_IN),
		.data_out(TGT_DATA_IN), .disc_out(TGT_DISC_IN));
	always #5 CLK_IN = ~CLK_IN;

	// Count fetched words and discard pulses of the current burst
	always @(posedge CLK_IN) begin
		if (TGT_DATA_IN === 1'b1) fcnt++;
		if (DISCARD_OUT === 1'b1) dcnt++;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic cyc;
		@(posedge CLK_IN);
		#1;
	endtask : cyc

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		check_count++;
		if (ex !== got) begin
			$display("unexpected %s expected %h seen %h", nm, ex, got);
			error_cnt++;
		end
	endtask : chk

	// Window to the aligned boundary; illegal sizes act as zero
	function automatic int exp_dw(input logic [3:0] c, input logic [31:0] a);
		int b;
		b = (CFG_CLS_IN inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h10}) ? int'(CFG_CLS_IN) : 16;
		if (c == brp_pkg::CMD_MEM_READ_MULT) b = b * 2;
		b = b << sh;
		if (b > 1024) b = 1024;
		return b - int'(a[31:2]) % b;
	endfunction : exp_dw

	// One read: issue, fetch, deliver dl words (negative picks at random)
	task automatic rd(input logic [3:0] c, input logic [31:0] a, input logic dn, ps, up,
		input int dc, input int dl);
		logic p;
		int e, n;
		p = c inside {brp_pkg::CMD_MEM_READ_LINE, brp_pkg::CMD_MEM_READ_MULT};
		p = p || (c == brp_pkg::CMD_MEM_READ && (dn ? ps : up));
		e = p ? exp_dw(c, a) : 1;
		REQ_CMD_IN = c;
		REQ_ADDR_IN = a;
		REQ_DOWNSTREAM_IN = dn;
		REQ_PREF_SPACE_IN = ps;
		CFG_UP_MR_PREF_IN = up;
		REQ_BE_N_IN = 4'($urandom);
		disc_at = 11'(dc);
		stall = 2'($urandom);
		REQ_VALID_IN = 1'b1;
		for (n = 0; n < 50 && REQ_READY_OUT !== 1'b1; n++) cyc;
		cyc;
		REQ_VALID_IN = 1'b0;
		fcnt = 0;
		dcnt = 0;
		for (n = 0; n < 50 && TGT_VALID_OUT !== 1'b1; n++) cyc;
		chk("tgt_pref", 32'(p), 32'(TGT_PREF_OUT));
		chk("tgt_be_n", 32'(p ? 4'h0 : REQ_BE_N_IN), 32'(TGT_BE_N_OUT));
		chk("tgt_cmd", 32'(c), 32'(TGT_CMD_OUT));
		chk("tgt_addr", a, TGT_ADDR_OUT);
		if (!FLOW_THROUGH_IN) chk("tgt_dwords", 32'(e), 32'(TGT_DWORDS_OUT));
		for (n = 0; n < 2100 && FETCH_STOP_OUT !== 1'b1; n++) cyc;
		fgot = fcnt;
		if (chk_f) chk("fetched", 32'(e < dc ? e : dc), 32'(fgot));
		if (dl < 0) dl = $urandom % (fgot + 1);
		if (fgot > 0) chk("init_disc", 32'(fgot == 1), 32'(INIT_DISC_OUT));
		INIT_XFER_IN = (dl > 0);
		repeat (dl) cyc;
		INIT_XFER_IN = 1'b0;
		if (dl < fgot) begin
			INIT_DONE_IN = 1'b1;
			cyc;
			INIT_DONE_IN = 1'b0;
		end
		// A read cut before the target took it still sits in the issue buffer
		for (n = 0; n < 50 && (BUSY_OUT !== 1'b0 || TGT_VALID_OUT === 1'b1); n++) cyc;
		cyc;
		chk("discard", 32'(dl < fgot), 32'(dcnt));
		chk("busy", 32'h0, 32'(BUSY_OUT));
	endtask : rd

	task automatic results;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	// Cut a hang short
	initial begin
		#400000;
		error_cnt++;
		results;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(63));
		repeat (8) @(posedge CLK_IN);
		#1;
		RST_N_IN = 1'b1;
		cyc;
		rd(brp_pkg::CMD_IO_READ, 32'h0000_1234, 1'b1, 1'b1, 1'b1, 5, 1);
		rd(brp_pkg::CMD_CFG_READ, 32'h0000_0010, 1'b1, 1'b1, 1'b1, 5, 1);
		rd(brp_pkg::CMD_MEM_READ, 32'h8000_0040, 1'b1, 1'b0, 1'b1, 5, 1);
		rd(brp_pkg::CMD_MEM_READ, 32'h8000_0044, 1'b0, 1'b1, 1'b0, 5, 0);
		rd(brp_pkg::CMD_MEM_READ, 32'h8000_0048, 1'b0, 1'b0, 1'b1, 9, -1);
		$display("test class done");
		CFG_CLS_IN = 8'h10;
		rd(brp_pkg::CMD_MEM_READ_MULT, 32'h0000_007c, 1'b1, 1'b0, 1'b0, 40, 1);
		CFG_CLS_IN = 8'h00;
		rd(brp_pkg::CMD_MEM_READ_LINE, 32'h0000_0000, 1'b1, 1'b0, 1'b0, 3, 2);
		$display("test boundary done");
		BUF_FREE_IN = 11'h001;
		chk_f = 1'b0;
		rd(brp_pkg::CMD_MEM_READ_MULT, 32'h0000_0000, 1'b1, 1'b0, 1'b0, 100, 0);
		chk("low_space", 32'h1, 32'(fgot < 32));
		BUF_FREE_IN = 11'h040;
		FLOW_THROUGH_IN = 1'b1;
		CFG_CLS_IN = 8'h01;
		rd(brp_pkg::CMD_MEM_READ_LINE, 32'h0000_1fc0, 1'b1, 1'b0, 1'b0, 2000, 0);
		chk("ft_4kb", 32'h10, 32'(fgot));
		fork
			begin
				repeat (25) cyc;
				INIT_FRAME_N_IN = 1'b1;
			end
			rd(brp_pkg::CMD_MEM_READ_LINE, 32'h0000_2000, 1'b1, 1'b0, 1'b0, 2000, 0);
		join
		chk("ft_frame", 32'h1, 32'(fgot > 16 && fgot < 40));
		INIT_FRAME_N_IN = 1'b0;
		FLOW_THROUGH_IN = 1'b0;
		chk_f = 1'b1;
		$display("test stop done");
		CFG_CLS_IN = 8'h04;
		CFG_DYN_PREF_IN = 2'h1;
		rd(brp_pkg::CMD_MEM_READ_LINE, 32'h0000_0000, 1'b1, 1'b0, 1'b0, 100, 4);
		chk("dyn_up", 32'h1, 32'(DYN_SHIFT_OUT));
		sh = 1;
		rd(brp_pkg::CMD_MEM_READ_LINE, 32'h0000_0000, 1'b1, 1'b0, 1'b0, 100, 1);
		chk("dyn_down", 32'h0, 32'(DYN_SHIFT_OUT));
		sh = 0;
		CFG_DYN_PREF_IN = 2'h0;
		$display("test dynamic done");
		for (i = 0; i < 25; i++) begin
			ALIAS_CMD_A_IN = cmds[i / 5];
			ALIAS_CMD_B_IN = cmds[i % 5];
			ALIAS_ADDR_EQ_IN = 1'($urandom);
			cyc;
			chk("alias", 32'(ALIAS_ADDR_EQ_IN && (i / 5 == i % 5 || (i / 5 inside {1, 3, 4}
				&& i % 5 inside {1, 3, 4}))), 32'(ALIAS_MATCH_OUT));
		end
		$display("test alias done");
		for (i = 0; i < 40; i++) begin
			CFG_CLS_IN = clsv[$urandom % 8];
			BUF_FREE_IN = 11'(2 + $urandom % 64);
			rd(cmds[$urandom % 5], $urandom & 32'hffff_fffc, 1'($urandom), 1'($urandom),
				1'($urandom), 1 + $urandom % 40, -1);
		end
		$display("test random done");
		results;
	end
endmodule : tb_brp_top

`default_nettype wire
